// File: rtl/sfw_pkg.sv
// Constants and types for the subtract execution datapath
`default_nettype none
package sfw_pkg;
   // ---------------------------------------------
   // Opcode decode
   // ---------------------------------------------
   localparam logic [5:0] OP_SUB  = 6'h17; // 0101 11
   localparam logic [5:0] OP_SUBB = 6'h16; // 0101 10
   localparam int         OP_MSB  = 15;
   localparam int         OP_LSB  = 10;
   localparam int         D_BIT   = 9;
   localparam int         A_BIT   = 8;
   localparam logic [7:0] IDX_MAX = 8'h5F; // last indexed offset

   // ---------------------------------------------
   // Register map (word index on the plain port)
   // ---------------------------------------------
   localparam logic [12:0] RA_ACC  = 13'h0000;
   localparam logic [12:0] RA_BANK = 13'h0001;
   localparam logic [12:0] RA_STAT = 13'h0002;
   localparam logic [12:0] RA_CTRL = 13'h0003;
   localparam logic [12:0] RA_IXLO = 13'h0004;
   localparam logic [12:0] RA_IXHI = 13'h0005;
   localparam int          RA_MEM  = 12; // set: data file

   // ---------------------------------------------
   // Status field positions and reset values
   // ---------------------------------------------
   localparam int C_POS  = 0;
   localparam int DIGIT_CARRY_POS = 1;
   localparam int Z_POS  = 2;
   localparam int OVERFLOW_POS = 3;
   localparam int N_POS  = 4;
   localparam int CTRL_EXT = 0;
   localparam logic [7:0]  ACC_RST  = 8'h00;
   localparam logic [3:0]  BANK_RST = 4'h0;
   localparam logic [4:0]  STAT_RST = 5'h00;
   localparam logic [11:0] IX_RST   = 12'h000;
   localparam logic [3:0]  ACC_LO_BANK = 4'h0; // access low
   localparam logic [3:0]  ACC_HI_BANK = 4'hF; // access high
   localparam int MEM_WORDS = 4096;

   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_Q1   = 3'h1,
      ST_Q2   = 3'h3,
      ST_Q3   = 3'h2,
      ST_Q4   = 3'h6
   } sfw_phase_t;

   typedef struct packed {
      logic       borrow; // variant with borrow
      logic       to_reg; // destination select
      logic       banked; // bank bit
      logic [7:0] fld;    // register field
   } sfw_op_t;

   typedef struct packed {
      logic n;
      logic overflow_flag;
      logic z;
      logic digit_carry_flag;
      logic c;
   } sfw_flags_t;
endpackage : sfw_pkg
`default_nettype wire

// File: rtl/sfw_exec.sv
// Execution datapath for the two subtract-from-file instructions
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RL1: Plain op: file value minus accumulator
// RL2: Borrow op subtracts inverted carry too
// RL3: Cleared carry removes one more, two's
// RL4: Destination bit 0 writes accumulator
// RL5: Destination bit 1 writes file register
// RL6: Bank bit picks bank register or access
// RL7: Extended set, low field: indexed offset
// RL8: Only N, overflow, C, digit carry, Z updated
// RL9: One word, four quarter phases
// RL10: Carry set when no borrow occurs
// RL11: Zero flag set on zero difference
// RL12: Result wraps, N copies bit seven
// RL13: Digit carry nibble no-borrow, overflow signed
// RL14: Read in Q2, compute in Q3, write in Q4
module sfw_exec (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic [15:0] instr,
   input  wire logic        instr_valid,
   input  wire logic [12:0] reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [7:0]       reg_rdata,
   output logic             busy,
   output logic             done,
   output logic             bad_op
);

   // ---------------------------------------------
   // State
   // ---------------------------------------------
   sfw_pkg::sfw_phase_t  ph_q;      // Quarter phase
   sfw_pkg::sfw_op_t     op_q;      // Decoded word
   sfw_pkg::sfw_flags_t  flg_q;     // Status flags
   logic [7:0]           acc_q;     // Accumulator
   logic [3:0]           bank_q;    // Bank select
   logic                 ext_q;     // Extended set on
   logic [11:0]          ix_q;      // Index base
   logic [11:0]          ea_q;      // Operand address
   logic [7:0]           opnd_q;    // Fetched operand
   logic [7:0]           res_q;     // Difference
   sfw_pkg::sfw_flags_t  nflg_q;    // New flags
   logic [7:0]           rdata_q;   // Read answer
   logic                 busy_q;    // Instruction live
   logic                 done_q;    // Writeback pulse
   logic                 bad_q;     // Refused opcode
   logic [7:0]           mem [sfw_pkg::MEM_WORDS]; // File

   // Combinational helpers
   logic                 take;      // Accept word
   logic                 is_sub;    // Plain opcode
   logic                 is_subb;   // Borrow opcode
   logic [11:0]          ea_d;      // Address next
   logic                 cin;       // Carry in
   logic [8:0]           diff;      // Nine-bit sum
   logic [4:0]           nib;       // Low nibble sum
   logic                 bus_mem;   // Bus hits file
   logic                 wb_reg;    // Q4 writes file
   logic                 wb_acc;    // Q4 writes acc

   assign reg_rdata = rdata_q;
   assign busy      = busy_q;
   assign done      = done_q;
   assign bad_op    = bad_q;

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   // New word only taken between instructions
   assign take    = instr_valid && (ph_q == sfw_pkg::ST_IDLE
                    || ph_q == sfw_pkg::ST_Q4);
   assign is_sub  = instr[sfw_pkg::OP_MSB:sfw_pkg::OP_LSB]
                    == sfw_pkg::OP_SUB;                       // [RL1]
   assign is_subb = instr[sfw_pkg::OP_MSB:sfw_pkg::OP_LSB]
                    == sfw_pkg::OP_SUBB;                      // [RL2]
   assign bus_mem = reg_addr[sfw_pkg::RA_MEM];
   // Writeback target follows the destination bit of the word
   assign wb_reg  = (ph_q == sfw_pkg::ST_Q4) && op_q.to_reg;  // [RL5]
   assign wb_acc  = (ph_q == sfw_pkg::ST_Q4) && !op_q.to_reg; // [RL4]

   // ---------------------------------------------
   // Operand address
   // ---------------------------------------------
   // Indexed offset wins over access bank only
   // with the extended set on and a low field
   always_comb begin
      // Banked form ignores the extended set entirely
      if (op_q.banked) begin
         ea_d = {bank_q, op_q.fld};                           // [RL6]
      end else if (ext_q && op_q.fld <= sfw_pkg::IDX_MAX) begin
         ea_d = ix_q + {4'h0, op_q.fld};                      // [RL7]
      end else if (op_q.fld <= sfw_pkg::IDX_MAX) begin
         ea_d = {sfw_pkg::ACC_LO_BANK, op_q.fld};             // [RL6]
      end else begin
         ea_d = {sfw_pkg::ACC_HI_BANK, op_q.fld};             // [RL6]
      end
   end

   // ---------------------------------------------
   // Arithmetic
   // ---------------------------------------------
   // f + ~w + cin; carry out is the no-borrow bit
   // The borrow variant feeds the stored carry in,
   // so a cleared carry takes one more away
   always_comb begin
      cin  = op_q.borrow ? flg_q.c : 1'b1;                    // [RL3]
      diff = {1'b0, opnd_q} + {1'b0, ~acc_q} + {8'h00, cin}; // [RL1] [RL2]
      nib  = {1'b0, opnd_q[3:0]} + {1'b0, ~acc_q[3:0]}
             + {4'h0, cin};                                   // [RL13]
   end

   // ---------------------------------------------
   // Quarter phase sequencer
   // ---------------------------------------------
   // Q4 may chain straight into the next Q1
   // Foreign words never leave idle; bad_op reports them
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ph_q <= sfw_pkg::ST_IDLE;
      end else begin
         case (ph_q)
            sfw_pkg::ST_IDLE: begin
               if (take && (is_sub || is_subb)) begin
                  ph_q <= sfw_pkg::ST_Q1;
               end
            end
            // Q1 to Q3 always advance; nothing stalls them
            sfw_pkg::ST_Q1: ph_q <= sfw_pkg::ST_Q2;          // [RL9]
            sfw_pkg::ST_Q2: ph_q <= sfw_pkg::ST_Q3;          // [RL9]
            sfw_pkg::ST_Q3: ph_q <= sfw_pkg::ST_Q4;          // [RL9]
            sfw_pkg::ST_Q4: begin
               if (take && (is_sub || is_subb)) begin
                  ph_q <= sfw_pkg::ST_Q1;                     // [RL14]
               end else begin
                  ph_q <= sfw_pkg::ST_IDLE;
               end
            end
            // Unused encodings fall back to idle
            default: ph_q <= sfw_pkg::ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------
   // Instruction capture and status pulses
   // ---------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         op_q   <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         bad_q  <= 1'b0;
      end else begin
         // Done marks Q4, the writeback cycle
         done_q <= ph_q == sfw_pkg::ST_Q3;
         // One-cycle report of a refused word
         bad_q  <= take && !(is_sub || is_subb);
         // Fields held until the next accepted word
         if (take && (is_sub || is_subb)) begin
            op_q.borrow <= is_subb;
            op_q.to_reg <= instr[sfw_pkg::D_BIT];
            op_q.banked <= instr[sfw_pkg::A_BIT];
            op_q.fld    <= instr[7:0];
         end
         // Busy covers Q1 through Q4
         if (take && (is_sub || is_subb)) begin
            busy_q <= 1'b1;
         end else if (ph_q == sfw_pkg::ST_Q4) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Q1 address, Q2 read, Q3 compute
   // ---------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         ea_q   <= 12'h000;
         opnd_q <= 8'h00;
         res_q  <= 8'h00;
         nflg_q <= '0;
      end else begin
         if (ph_q == sfw_pkg::ST_Q1) begin
            ea_q <= ea_d;
         end
         if (ph_q == sfw_pkg::ST_Q2) begin
            opnd_q <= mem[ea_q];                             // [RL9]
         end
         // Flags are staged here and land together in Q4
         if (ph_q == sfw_pkg::ST_Q3) begin
            res_q                   <= diff[7:0];            // [RL12]
            nflg_q.c                <= diff[8];              // [RL10]
            nflg_q.digit_carry_flag <= nib[4];               // [RL13]
            nflg_q.z                <= diff[7:0] == 8'h00;   // [RL11]
            nflg_q.n                <= diff[7];              // [RL12]
            // Signed overflow: operand signs differ and the
            // result sign left that of the file value
            nflg_q.overflow_flag    <= (opnd_q[7] != acc_q[7])
                                       && (diff[7] != opnd_q[7]); // [RL13]
         end
      end
   end

   // ---------------------------------------------
   // Data file
   // ---------------------------------------------
   // Writeback owns the port in Q4 when d is 1; a bus write
   // to the file in that cycle is dropped
   // No reset here: the file keeps its bytes across nrst
   always_ff @(posedge clk_sys) begin
      if (wb_reg) begin
         mem[ea_q] <= res_q;                                 // [RL5]
      end else if (reg_wr && bus_mem) begin
         mem[reg_addr[11:0]] <= reg_wdata;
      end
   end

   // ---------------------------------------------
   // Accumulator
   // ---------------------------------------------
   // Writeback beats the bus only when d is 0
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         acc_q <= sfw_pkg::ACC_RST;
      end else if (wb_acc) begin
         acc_q <= res_q;                                     // [RL4]
      end else if (reg_wr && reg_addr == sfw_pkg::RA_ACC) begin
         acc_q <= reg_wdata;
      end
   end

   // ---------------------------------------------
   // Status flags
   // ---------------------------------------------
   // Every Q4 rewrites all five flags, whatever
   // the destination; the bus loses that cycle
   // A bus write to status lands outside Q4 only
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         flg_q <= sfw_pkg::STAT_RST;
      end else if (ph_q == sfw_pkg::ST_Q4) begin
         flg_q <= nflg_q;                                    // [RL8]
      end else if (reg_wr && reg_addr == sfw_pkg::RA_STAT) begin
         flg_q <= reg_wdata[4:0];
      end
   end

   // ---------------------------------------------
   // Bank, control and index registers
   // ---------------------------------------------
   // Changing these mid-instruction only takes
   // effect if done before Q1 of that word
   // Index base is written as low byte and high nibble
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         bank_q <= sfw_pkg::BANK_RST;
         ext_q  <= 1'b0;
         ix_q   <= sfw_pkg::IX_RST;
      end else if (reg_wr) begin
         case (reg_addr)
            sfw_pkg::RA_BANK: bank_q <= reg_wdata[3:0];
            sfw_pkg::RA_CTRL: ext_q <= reg_wdata[sfw_pkg::CTRL_EXT];
            sfw_pkg::RA_IXLO: ix_q[7:0] <= reg_wdata;
            sfw_pkg::RA_IXHI: ix_q[11:8] <= reg_wdata[3:0];
            default: ;
         endcase
      end
   end

   // ---------------------------------------------
   // Read port
   // ---------------------------------------------
   // Answer stands one cycle; unmapped reads 00
   // Status reads pad the three spare bits with 0
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rdata_q <= 8'h00;
      end else if (!reg_rd) begin
         rdata_q <= 8'h00;
      end else if (bus_mem) begin
         rdata_q <= mem[reg_addr[11:0]];
      end else begin
         case (reg_addr)
            sfw_pkg::RA_ACC:  rdata_q <= acc_q;
            sfw_pkg::RA_BANK: rdata_q <= {4'h0, bank_q};
            sfw_pkg::RA_STAT: rdata_q <= {3'h0, flg_q};
            sfw_pkg::RA_CTRL: rdata_q <= {7'h00, ext_q};
            sfw_pkg::RA_IXLO: rdata_q <= ix_q[7:0];
            sfw_pkg::RA_IXHI: rdata_q <= {4'h0, ix_q[11:8]};
            default:          rdata_q <= 8'h00;
         endcase
      end
   end

endmodule : sfw_exec

`default_nettype wire

// File: sim/sfw_exec_sva.sv
// Port-level assertions for the subtract execution datapath
`timescale 1ns/1ps
`default_nettype none
module sfw_exec_chk (
   input wire logic        clk_sys,
   input wire logic        nrst,
   input wire logic [15:0] instr,
   input wire logic        instr_valid,
   input wire logic [12:0] reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_rdata,
   input wire logic        busy,
   input wire logic        done,
   input wire logic        bad_op
);
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   logic take;   // Word taken at this edge
   logic is_sub; // Opcode is 0101_1x
   assign take   = instr_valid && (!busy || done);
   assign is_sub = instr[15:11] == 5'b01011;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   property p_done4; take && is_sub |-> ##4 done; endproperty
   a_done4: assert property (p_done4) else $error("done not four cycles on");
   property p_busy4; take && is_sub |=> busy [*4]; endproperty
   a_busy4: assert property (p_busy4) else $error("busy gap in the cycle");
   property p_idle; done && !(take && is_sub) |=> !busy && !done; endproperty
   a_idle: assert property (p_idle) else $error("busy after last phase");
   property p_bad; take && !is_sub |=> bad_op && !busy; endproperty
   a_bad: assert property (p_bad) else $error("foreign opcode not flagged");
   property p_ign; instr_valid && busy && !done |=> !bad_op; endproperty
   a_ign: assert property (p_ign) else $error("word mid-cycle not ignored");
   property p_dpulse; done |=> !done; endproperty
   a_dpulse: assert property (p_dpulse) else $error("done wider than one");
   property p_dbusy; done |-> busy && $past(busy, 3); endproperty
   a_dbusy: assert property (p_dbusy) else $error("done without phases");
   property p_stat; reg_rd && reg_addr == sfw_pkg::RA_STAT |=> reg_rdata[7:5] == 3'b000;
   endproperty
   a_stat: assert property (p_stat) else $error("stray status bits");
endmodule : sfw_exec_chk

bind sfw_exec sfw_exec_chk i_chk (.clk_sys(clk_sys), .nrst(nrst), .instr(instr),
   .instr_valid(instr_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
   .done(done), .bad_op(bad_op));
`default_nettype wire

// File: sim/sfw_exec_tb.sv
// Self-checking bench for the subtract execution datapath
`timescale 1ns/1ps
`default_nettype none
module sfw_exec_tb;
   // ---------------------------------------------
   // Case table: op, dest, carry in, f, acc, result, flags
   // ---------------------------------------------
   typedef struct packed {
      logic       bo, d, ci;
      logic [7:0] f, w, r;
      logic [4:0] fl;
   } sfw_row_t;
   localparam sfw_row_t ROWS [8] = '{
      '{1'b0, 1'b1, 1'b0, 8'h03, 8'h02, 8'h01, 5'h03},
      '{1'b0, 1'b0, 1'b0, 8'h02, 8'h02, 8'h00, 5'h07},
      '{1'b0, 1'b1, 1'b0, 8'h01, 8'h02, 8'hff, 5'h10},
      '{1'b1, 1'b1, 1'b1, 8'h19, 8'h0d, 8'h0c, 5'h01},
      '{1'b1, 1'b0, 1'b0, 8'h1b, 8'h1a, 8'h00, 5'h07},
      '{1'b1, 1'b1, 1'b1, 8'h03, 8'h0e, 8'hf5, 5'h10},
      '{1'b0, 1'b0, 1'b1, 8'h80, 8'h01, 8'h7f, 5'h09},
      '{1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 8'hff, 5'h10}};
   logic        clk_sys, nrst, instr_valid, reg_wr, reg_rd, busy, done, bad_op;
   logic [15:0] instr;
   logic [12:0] reg_addr;
   logic [7:0]  reg_wdata, reg_rdata, rv;
   int          error_cnt, check_count, n;

   sfw_exec i_dut (.clk_sys(clk_sys), .nrst(nrst), .instr(instr),
      .instr_valid(instr_valid), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy),
      .done(done), .bad_op(bad_op));

   // Free-running 100 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // One-cycle write strobe, gap before the next
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [12:0] a);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask : rd
   // Bounded wait for done; n counts edges after taking
   task automatic wt;
      for (n = 1; n <= 10; n++) begin
         @(posedge clk_sys);
         #1;
         if (done === 1'b1) break;
      end
      if (n > 10) begin
         error_cnt++;
         test_done();
      end
   endtask : wt
   task automatic go(input logic [15:0] i);
      @(posedge clk_sys);
      instr       <= i;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      wt();
   endtask : go
   // File 09h minus acc 02h back to the file at fa
   task automatic at(input logic [7:0] ctl, input logic [3:0] bk, input logic a,
                     input logic [7:0] f, input logic [12:0] fa);
      wr(sfw_pkg::RA_CTRL, ctl);
      wr(sfw_pkg::RA_BANK, {4'h0, bk});
      wr(fa, 8'h09);
      wr(sfw_pkg::RA_ACC, 8'h02);
      go({sfw_pkg::OP_SUB, 1'b1, a, f});
      rd(fa);
      chk(rv, 8'h07);
   endtask : at

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      {nrst, instr_valid, reg_wr, reg_rd} = 4'h0;
      {instr, reg_addr, reg_wdata} = '0;
      error_cnt   = 0;
      check_count = 0;
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      rd(sfw_pkg::RA_STAT);
      chk(rv, 8'h00);
      wr(sfw_pkg::RA_IXHI, 8'h02);
      for (int k = 0; k < 8; k++) begin
         wr(sfw_pkg::RA_STAT, {7'h00, ROWS[k].ci});
         wr(sfw_pkg::RA_ACC, ROWS[k].w);
         wr(13'h1010, ROWS[k].f);
         go({ROWS[k].bo ? sfw_pkg::OP_SUBB : sfw_pkg::OP_SUB, ROWS[k].d, 1'b0, 8'h10});
         chk(8'(n), 8'h03);
         rd(sfw_pkg::RA_ACC);
         chk(rv, ROWS[k].d ? ROWS[k].w : ROWS[k].r);
         rd(13'h1010);
         chk(rv, ROWS[k].d ? ROWS[k].r : ROWS[k].f);
         rd(sfw_pkg::RA_STAT);
         chk(rv, {3'b000, ROWS[k].fl});
      end
      // Operand addressing corners
      at(8'h00, 4'h3, 1'b1, 8'h10, 13'h1310);
      at(8'h00, 4'h3, 1'b0, 8'h80, 13'h1f80);
      at(8'h01, 4'h3, 1'b0, 8'h5f, 13'h125f);
      at(8'h01, 4'h3, 1'b0, 8'h60, 13'h1f60);
      at(8'h01, 4'h3, 1'b1, 8'h10, 13'h1310);
      // Neighbouring opcode must be refused
      wr(sfw_pkg::RA_ACC, 8'h33);
      @(posedge clk_sys);
      instr       <= 16'h5410;
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      #1 chk({7'h00, bad_op}, 8'h01);
      rd(sfw_pkg::RA_ACC);
      chk(rv, 8'h33);
      // Held into Q1 (ignored), offered again in Q4: acc hazard
      wr(13'h1010, 8'h05);
      wr(sfw_pkg::RA_ACC, 8'h01);
      @(posedge clk_sys);
      instr       <= {sfw_pkg::OP_SUB, 2'b00, 8'h10};
      instr_valid <= 1'b1;
      repeat (2) @(posedge clk_sys);
      instr_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      wt();
      rd(sfw_pkg::RA_ACC);
      chk(rv, 8'h01);
      // Reset in mid-instruction: state back to reset values
      wr(sfw_pkg::RA_BANK, 8'h05);
      @(posedge clk_sys);
      instr       <= {sfw_pkg::OP_SUB, 2'b00, 8'h10};
      instr_valid <= 1'b1;
      @(posedge clk_sys);
      instr_valid <= 1'b0;
      @(posedge clk_sys);
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      #1 chk({6'h00, busy, done}, 8'h00);
      rd(sfw_pkg::RA_ACC);
      chk(rv, 8'h00);
      rd(sfw_pkg::RA_BANK);
      chk(rv, 8'h00);
      rd(sfw_pkg::RA_CTRL);
      chk(rv, 8'h00);
      rd(sfw_pkg::RA_STAT);
      chk(rv, 8'h00);
      test_done();
   end
endmodule : sfw_exec_tb
`default_nettype wire
